// file: common/imc_pkg.sv
// Constants, register map and carrier types of the input mapping and mode control block.
package imc_pkg;

  localparam int IMC_NCH = 8;
  localparam int IMC_AW = 8;
  localparam int IMC_DW = 32;
  localparam int IMC_NPG = 2;

  localparam logic [IMC_AW-1:0] IMC_OFF_OUT = 8'h00;
  localparam logic [IMC_AW-1:0] IMC_OFF_MAP_A = 8'h04;
  localparam logic [IMC_AW-1:0] IMC_OFF_MAP_B = 8'h08;
  localparam logic [IMC_AW-1:0] IMC_OFF_PG0_MAP = 8'h0c;
  localparam logic [IMC_AW-1:0] IMC_OFF_PG1_MAP = 8'h10;
  localparam logic [IMC_AW-1:0] IMC_OFF_LEVEL_MON = 8'h14;
  localparam logic [IMC_AW-1:0] IMC_OFF_MODE = 8'h18;

  localparam int IMC_CH_A_DEF = 2;
  localparam int IMC_CH_B_DEF = 3;
  localparam logic [IMC_NCH-1:0] IMC_OUT_RST = 8'h00;
  localparam logic [IMC_NCH-1:0] IMC_MAP_A_RST = 8'h04;
  localparam logic [IMC_NCH-1:0] IMC_MAP_B_RST = 8'h08;
  localparam logic [IMC_NCH-1:0] IMC_PG_MAP_RST = 8'h00;

  typedef logic [IMC_NCH-1:0] imc_ch_t;

  typedef enum logic [1:0] {
    IMC_NORMAL,
    IMC_SLEEP,
    IMC_LIMP
  } imc_mode_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [IMC_AW-1:0] paddr;
    logic [IMC_DW-1:0] pwdata;
  } imc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [IMC_DW-1:0] prdata;
  } imc_apb_rsp_s;

endpackage

// file: src/imc_top.sv
// Direct input mapping, channel drive and sleep or fallback mode control with an APB register slave.
`timescale 1ns/100ps
// How it works
// - After reset input A drives only channel 2 and input B drives only channel 3.
// - Each input has its own map register whose written value selects every channel that input drives.
// - A channel is on when its output register bit, a mapped pulse generator or a mapped direct input says so.
// - The input level monitor register reads back the present level of both direct inputs.
// - The input level monitor keeps following the inputs while the device is in fallback mode.
// - With the sleep request pin low and any direct input high the device enters fallback mode and drives the default channel.
// - With the sleep request pin low and both direct inputs low the device enters sleep mode.
// - While the sleep request pin is low the output, input map and pulse generator map registers are held at their default values.
// - In sleep mode the undervoltage detection is switched off.
// - In sleep mode serial access is refused and the serial output stays undriven even with chip select low.
module imc_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire imc_pkg::imc_apb_req_s apb_req,
  output imc_pkg::imc_apb_rsp_s apb_rsp,
  input wire logic direct_input_a,
  input wire logic direct_input_b,
  input wire logic sleep_req_n,
  input wire logic [imc_pkg::IMC_NPG-1:0] pulse_gen,
  input wire logic chip_select_n,
  output imc_pkg::imc_ch_t channel_on,
  output imc_pkg::imc_mode_e mode,
  output logic [1:0] input_level_monitor,
  output logic uv_detect_en,
  output logic serial_enable,
  output logic serial_so_oe_n
);
  import imc_pkg::*;

  imc_mode_e next_mode;
  imc_ch_t out_reg;
  imc_ch_t input_a_channel_map;
  imc_ch_t input_b_channel_map;
  imc_ch_t pg_map [IMC_NPG];
  imc_ch_t next_on;
  logic bus_ok;
  logic access;
  logic wr_fire;
  logic rd_hit;
  logic [IMC_DW-1:0] rd_data;

  // The pin levels are decoded every cycle; the host keeps the sleep request level steady for the hold time.
  always_comb begin
    if (sleep_req_n) begin
      next_mode = IMC_NORMAL;
    end else if (direct_input_a || direct_input_b) begin
      next_mode = IMC_LIMP;
    end else begin
      next_mode = IMC_SLEEP;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode <= IMC_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // Writes are only taken in normal mode, so a write that races the pin falling cannot survive the forced reset.
  assign bus_ok = sleep_req_n && (mode == IMC_NORMAL);
  assign access = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  assign wr_fire = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && bus_ok && !apb_rsp.pslverr;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= IMC_OUT_RST;
      input_a_channel_map <= IMC_MAP_A_RST;
      input_b_channel_map <= IMC_MAP_B_RST;
    end else if (!sleep_req_n) begin
      out_reg <= IMC_OUT_RST;
      input_a_channel_map <= IMC_MAP_A_RST;
      input_b_channel_map <= IMC_MAP_B_RST;
    end else if (wr_fire) begin
      case (apb_req.paddr)
        IMC_OFF_OUT: begin
          out_reg <= apb_req.pwdata[IMC_NCH-1:0];
        end
        IMC_OFF_MAP_A: begin
          input_a_channel_map <= apb_req.pwdata[IMC_NCH-1:0];
        end
        IMC_OFF_MAP_B: begin
          input_b_channel_map <= apb_req.pwdata[IMC_NCH-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pg_map[0] <= IMC_PG_MAP_RST;
      pg_map[1] <= IMC_PG_MAP_RST;
    end else if (!sleep_req_n) begin
      pg_map[0] <= IMC_PG_MAP_RST;
      pg_map[1] <= IMC_PG_MAP_RST;
    end else if (wr_fire && apb_req.paddr == IMC_OFF_PG0_MAP) begin
      pg_map[0] <= apb_req.pwdata[IMC_NCH-1:0];
    end else if (wr_fire && apb_req.paddr == IMC_OFF_PG1_MAP) begin
      pg_map[1] <= apb_req.pwdata[IMC_NCH-1:0];
    end
  end

  // In fallback mode the maps are at their defaults, so each high input lights its default channel.
  for (genvar ch = 0; ch < IMC_NCH; ch++) begin : g_drive
    assign next_on[ch] = out_reg[ch] | (pg_map[0][ch] & pulse_gen[0]) | (pg_map[1][ch] & pulse_gen[1])
                       | (input_a_channel_map[ch] & direct_input_a)
                       | (input_b_channel_map[ch] & direct_input_b);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      channel_on <= IMC_OUT_RST;
    end else begin
      channel_on <= next_on;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      input_level_monitor <= 2'h0;
    end else begin
      input_level_monitor <= {direct_input_b, direct_input_a};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      uv_detect_en <= 1'b1;
      serial_enable <= 1'b1;
      serial_so_oe_n <= 1'b1;
    end else begin
      uv_detect_en <= (next_mode != IMC_SLEEP);
      serial_enable <= (next_mode != IMC_SLEEP);
      serial_so_oe_n <= !((next_mode != IMC_SLEEP) && !chip_select_n);
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    case (apb_req.paddr)
      IMC_OFF_OUT: begin
        rd_data[IMC_NCH-1:0] = out_reg;
      end
      IMC_OFF_MAP_A: begin
        rd_data[IMC_NCH-1:0] = input_a_channel_map;
      end
      IMC_OFF_MAP_B: begin
        rd_data[IMC_NCH-1:0] = input_b_channel_map;
      end
      IMC_OFF_PG0_MAP: begin
        rd_data[IMC_NCH-1:0] = pg_map[0];
      end
      IMC_OFF_PG1_MAP: begin
        rd_data[IMC_NCH-1:0] = pg_map[1];
      end
      IMC_OFF_LEVEL_MON: begin
        rd_data[1:0] = input_level_monitor;
      end
      IMC_OFF_MODE: begin
        rd_data[1:0] = mode;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // One wait state keeps the answer registered; refused accesses still complete so the master never hangs.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= access;
      apb_rsp.pslverr <= access && (!bus_ok || !rd_hit);
      apb_rsp.prdata <= (access && bus_ok && !apb_req.pwrite) ? rd_data : '0;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_default_maps_held: assert property (!sleep_req_n |=> input_a_channel_map == IMC_MAP_A_RST
    && input_b_channel_map == IMC_MAP_B_RST && out_reg == IMC_OUT_RST)
    else $error("Registers not at defaults while sleep request is low.");
  chk_map_write_lands: assert property (wr_fire && apb_req.paddr == IMC_OFF_MAP_A
    |=> input_a_channel_map == $past(apb_req.pwdata[IMC_NCH-1:0]))
    else $error("Input A map write lost.");
  chk_channel_or: assert property (direct_input_a && sleep_req_n
    |=> (channel_on & $past(input_a_channel_map)) == $past(input_a_channel_map))
    else $error("Mapped channel not on with input A high.");
  chk_monitor_in_limp: assert property (mode == IMC_LIMP |-> input_level_monitor == $past({direct_input_b,
    direct_input_a}))
    else $error("Input level monitor stopped in fallback mode.");
  chk_limp_channel_on: assert property ((!sleep_req_n && direct_input_b) [*2] |=> mode == IMC_LIMP
    && channel_on[IMC_CH_B_DEF])
    else $error("Fallback mode did not drive the default channel.");
  chk_sleep_entry: assert property (!sleep_req_n && !direct_input_a && !direct_input_b |=> mode == IMC_SLEEP)
    else $error("Sleep mode not entered.");
  chk_sleep_quiet: assert property (mode == IMC_SLEEP |-> !uv_detect_en && !serial_enable && serial_so_oe_n)
    else $error("Sleep mode left detection or serial output active.");
  chk_bus_refused: assert property (access && !sleep_req_n |=> apb_rsp.pready && apb_rsp.pslverr
    && apb_rsp.prdata == '0)
    else $error("Bus access not refused in sleep or fallback.");
  chk_wake_normal: assert property ($rose(sleep_req_n) |=> mode == IMC_NORMAL ##1 bus_ok || !sleep_req_n)
    else $error("Device did not return to normal mode.");

  // A refusal is decided at the access edge, so a wake-up during the wait state cannot let the write slip in.

  chk_map_b_write: assert property (wr_fire && apb_req.paddr == IMC_OFF_MAP_B
    |=> input_b_channel_map == $past(apb_req.pwdata[IMC_NCH-1:0]))
    else $error("Input B map write lost.");

  chk_out_write: assert property (wr_fire && apb_req.paddr == IMC_OFF_OUT
    |=> out_reg == $past(apb_req.pwdata[IMC_NCH-1:0]))
    else $error("Output register write lost.");

  chk_pg0_write: assert property (wr_fire && apb_req.paddr == IMC_OFF_PG0_MAP
    |=> pg_map[0] == $past(apb_req.pwdata[IMC_NCH-1:0]))
    else $error("Pulse generator 0 map write lost.");

  chk_pg1_write: assert property (wr_fire && apb_req.paddr == IMC_OFF_PG1_MAP
    |=> pg_map[1] == $past(apb_req.pwdata[IMC_NCH-1:0]))
    else $error("Pulse generator 1 map write lost.");

  chk_channel_or_b: assert property (direct_input_b && sleep_req_n
    |=> (channel_on & $past(input_b_channel_map)) == $past(input_b_channel_map))
    else $error("Mapped channel not on with input B high.");

  chk_channel_out: assert property (sleep_req_n
    |=> (channel_on & $past(out_reg)) == $past(out_reg))
    else $error("Output register bit did not switch its channel on.");

  chk_channel_pg0: assert property (pulse_gen[0]
    |=> (channel_on & $past(pg_map[0])) == $past(pg_map[0]))
    else $error("Pulse generator 0 did not drive its mapped channels.");

  chk_channel_pg1: assert property (pulse_gen[1]
    |=> (channel_on & $past(pg_map[1])) == $past(pg_map[1]))
    else $error("Pulse generator 1 did not drive its mapped channels.");

  chk_monitor_follows: assert property (sleep_req_n || !sleep_req_n
    |=> input_level_monitor == $past({direct_input_b, direct_input_a}))
    else $error("Input level monitor does not follow the pins.");

  chk_monitor_read: assert property (access && bus_ok && !apb_req.pwrite && apb_req.paddr == IMC_OFF_LEVEL_MON
    |=> apb_rsp.prdata == {30'h0, $past(input_level_monitor)})
    else $error("Input level monitor read returned a wrong value.");

  chk_limp_entry_a: assert property (!sleep_req_n && direct_input_a
    |=> mode == IMC_LIMP)
    else $error("Fallback mode not entered with input A high.");

  chk_limp_a_channel: assert property ((!sleep_req_n && direct_input_a) [*2]
    |=> channel_on[IMC_CH_A_DEF])
    else $error("Fallback mode did not drive the default channel of input A.");

  chk_normal_mode: assert property (sleep_req_n
    |=> mode == IMC_NORMAL)
    else $error("Normal mode not taken with sleep request high.");

  chk_normal_active: assert property (mode == IMC_NORMAL
    |-> uv_detect_en && serial_enable)
    else $error("Detection or serial interface off in normal mode.");

  chk_limp_uv_on: assert property (mode == IMC_LIMP
    |-> uv_detect_en && serial_enable)
    else $error("Detection or serial interface off in fallback mode.");

  chk_so_idle: assert property (chip_select_n
    |=> serial_so_oe_n)
    else $error("Serial output driven without chip select.");

  chk_sleep_so_off: assert property (!sleep_req_n && !direct_input_a && !direct_input_b
    |=> serial_so_oe_n && !serial_enable)
    else $error("Serial interface active in sleep mode.");

  chk_sleep_uv_off: assert property (!sleep_req_n && !direct_input_a && !direct_input_b
    |=> !uv_detect_en)
    else $error("Undervoltage detection active in sleep mode.");

  chk_pg_held: assert property (!sleep_req_n
    |=> pg_map[0] == IMC_PG_MAP_RST && pg_map[1] == IMC_PG_MAP_RST)
    else $error("Pulse generator maps not at defaults while sleep request is low.");

  chk_wake_bus: assert property ($rose(sleep_req_n)
    |=> bus_ok || !sleep_req_n)
    else $error("Bus not accepted after wake-up.");

  chk_map_read: assert property (access && bus_ok && !apb_req.pwrite && apb_req.paddr == IMC_OFF_MAP_A
    |=> !apb_rsp.pslverr && apb_rsp.prdata == {24'h0, $past(input_a_channel_map)})
    else $error("Input A map read returned a wrong value.");

  chk_sleep_refused: assert property (mode == IMC_SLEEP && access
    |=> apb_rsp.pslverr)
    else $error("Bus access not refused in sleep mode.");

  chk_default_channels: assert property (!sleep_req_n
    |=> input_a_channel_map == imc_ch_t'(1 << IMC_CH_A_DEF) && input_b_channel_map == imc_ch_t'(1 << IMC_CH_B_DEF))
    else $error("Default maps do not select the default channels.");

  chk_ready_answer: assert property (access
    |=> apb_rsp.pready)
    else $error("Bus access not answered after one wait state.");

  chk_ready_pulse: assert property (apb_rsp.pready
    |=> !apb_rsp.pready)
    else $error("Bus ready stood longer than one cycle.");

  chk_unmapped_error: assert property (access && !rd_hit
    |=> apb_rsp.pslverr)
    else $error("Unmapped address not refused.");

  chk_mode_legal: assert property (sleep_req_n || !sleep_req_n
    |-> mode inside {IMC_NORMAL, IMC_SLEEP, IMC_LIMP})
    else $error("Mode register holds an unused code.");

  chk_limp_maps_default: assert property (mode == IMC_LIMP
    |-> input_a_channel_map == IMC_MAP_A_RST && input_b_channel_map == IMC_MAP_B_RST)
    else $error("Maps not at defaults in fallback mode.");

  chk_refused_write_lost: assert property (apb_rsp.pready && apb_rsp.pslverr && sleep_req_n
    |=> $stable(input_a_channel_map) && $stable(input_b_channel_map))
    else $error("Refused write changed a map register.");

  cov_limp: cover property (mode == IMC_NORMAL ##1 mode == IMC_LIMP);
  cov_limp_exit: cover property (mode == IMC_LIMP ##1 mode == IMC_NORMAL);
  cov_refused: cover property (apb_rsp.pready && apb_rsp.pslverr);
  cov_sleep_wake: cover property (mode == IMC_SLEEP ##1 mode == IMC_NORMAL);
  cov_map_write: cover property (wr_fire && apb_req.paddr == IMC_OFF_MAP_B);

endmodule

// file: tb/imc_host_model.sv
// Host model that drives the direct input, sleep request and chip select pins.
`timescale 1ns/100ps
module imc_host_model #(
  parameter int HOLD = 3
) (
  input wire logic core_clk,
  input wire logic [3:0] want,
  output logic direct_input_a,
  output logic direct_input_b,
  output logic sleep_req_n,
  output logic chip_select_n
);
  int held = 0;
  initial begin
    {chip_select_n, sleep_req_n, direct_input_b, direct_input_a} = 4'hc;
  end
  // A new sleep level is kept at least HOLD cycles, so a mode change is never cut short.
  always @(posedge core_clk) begin
    {chip_select_n, direct_input_b, direct_input_a} <= {want[3], want[1:0]};
    held <= held + 1;
    if (want[2] != sleep_req_n && held >= HOLD) begin
      sleep_req_n <= want[2];
      held <= 0;
    end
  end
endmodule

// file: tb/imc_top_test.sv
// Self-checking bench for input mapping, channel drive and mode control.
`timescale 1ns/100ps
module imc_top_test;
  import imc_pkg::*;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] ma;
    logic [7:0] mb;
    logic [1:0] ba;
    logic [1:0] pg;
    logic [7:0] exp_ch;
  } imc_row_s;
  localparam imc_row_s ROWS [5] = '{
    '{8'h00, 8'h04, 8'h08, 2'h1, 2'h0, 8'h04},
    '{8'h00, 8'h04, 8'h08, 2'h2, 2'h0, 8'h08},
    '{8'h01, 8'h30, 8'h08, 2'h1, 2'h1, 8'hb1},
    '{8'h00, 8'h30, 8'h40, 2'h3, 2'h2, 8'h70},
    '{8'h00, 8'h00, 8'h00, 2'h3, 2'h0, 8'h00}};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] want = 4'hc;
  logic [1:0] pulse_gen = 2'h0;
  imc_apb_req_s req = '0;
  imc_apb_rsp_s rsp;
  imc_ch_t channel_on;
  imc_mode_e mode;
  logic [1:0] mon;
  logic uv, sen, so_oe_n, a, b, slp_n, cs_n;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  imc_host_model host_u (.core_clk(core_clk), .want(want), .direct_input_a(a), .direct_input_b(b),
    .sleep_req_n(slp_n), .chip_select_n(cs_n));
  imc_top dut_u (.core_clk(core_clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .direct_input_a(a),
    .direct_input_b(b), .sleep_req_n(slp_n), .pulse_gen(pulse_gen), .chip_select_n(cs_n),
    .channel_on(channel_on), .mode(mode), .input_level_monitor(mon), .uv_detect_en(uv),
    .serial_enable(sen), .serial_so_oe_n(so_oe_n));
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // A hung slave would stall the run, so the access phase is bounded.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, w, ad, wd};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
  endtask
  initial begin
    cyc(10);
    chk(32'({uv, sen, so_oe_n, channel_on}), 32'h700);
    rstn <= 1'b1;
    apb(1'b0, IMC_OFF_MAP_A, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, IMC_OFF_MAP_B, 32'h0);
    chk(rd, 32'h8);
    apb(1'b1, IMC_OFF_PG0_MAP, 32'h80);
    foreach (ROWS[i]) begin
      apb(1'b1, IMC_OFF_OUT, {24'h0, ROWS[i].out});
      apb(1'b1, IMC_OFF_MAP_A, {24'h0, ROWS[i].ma});
      apb(1'b1, IMC_OFF_MAP_B, {24'h0, ROWS[i].mb});
      want <= {2'b11, ROWS[i].ba};
      pulse_gen <= ROWS[i].pg;
      cyc(4);
      chk(32'(channel_on), 32'(ROWS[i].exp_ch));
      chk(32'(mon), 32'(ROWS[i].ba));
      apb(1'b0, IMC_OFF_LEVEL_MON, 32'h0);
      chk(rd, 32'(ROWS[i].ba));
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    want <= 4'h9;
    cyc(8);
    chk(32'(mode), 32'(IMC_LIMP));
    chk(32'(channel_on), 32'h04);
    want <= 4'hb;
    cyc(3);
    chk(32'(mon), 32'h3);
    chk(32'(channel_on), 32'h0c);
    apb(1'b0, IMC_OFF_MAP_A, 32'h0);
    chk(32'(er), 32'h1);
    want <= 4'h0;
    cyc(4);
    chk(32'(mode), 32'(IMC_SLEEP));
    chk(32'(uv), 32'h0);
    chk(32'({sen, so_oe_n}), 32'h1);
    want <= 4'h4;
    cyc(8);
    chk(32'(mode), 32'(IMC_NORMAL));
    chk(32'({uv, sen, so_oe_n}), 32'h6);
    apb(1'b0, IMC_OFF_MAP_A, 32'h0);
    chk(32'(er), 32'h0);
    chk(rd, 32'h4);
    end_of_test();
  end
endmodule
